// [hdl/bilr_defines.svh]
// Constants for the immediate branch, load/store and reservation unit
// Summary of operation
// (RULE1) Opcode 101111 is a conditional immediate branch testing register A against zero by code 0-5, target PC plus sign-extended immediate.
// (RULE2) Conditional codes 10000 to 10101 take the same test and target as the delayed variant.
// (RULE3) Opcode 101110 is an unconditional immediate branch, relative or absolute, delayed or not, optional link, or the break form.
// Here a link issued as any load or store completes loses its write-back.
// (RULE4) Effective address is A plus B or A plus sign-extended immediate; narrow loads zero-fill, narrow stores write only the low part.
// (RULE5) The reserving load loads the word and sets the reservation flag.
// (RULE6) The conditional store writes only while the flag is set and clears the flag afterwards.
// (RULE7) A conditional store that finds a reservation writes memory and clears the carry status bit.
// (RULE8) A conditional store that finds no reservation issues no write and sets the carry status bit.
// (RULE9) The reservation covers one whole word and both instructions use word-aligned addresses.
// (RULE10) The reserving load and conditional store never raise an unaligned-access exception.
// (RULE11) The conditional store succeeds whenever a reservation exists, with no address compare.
// (RULE12) At most one reservation is held; a later reserving load replaces the earlier one.
// (RULE13) Every conditional store leaves the reservation cleared.
// (RULE14) Software pairs each reserving load with a conditional store to the same address.
// (RULE15) Other masters may read the reserved location meanwhile; nothing blocks them.
// (RULE16) Reset, interrupts, exceptions and breaks clear the reservation.
`ifndef BILR_DEFINES_SVH
`define BILR_DEFINES_SVH
`define BILR_OP_BRU 6'h2E
`define BILR_OP_BRC 6'h2F
`define BILR_OP_LBU 6'h30
`define BILR_OP_LHU 6'h31
`define BILR_OP_LW 6'h32
`define BILR_OP_SB 6'h34
`define BILR_OP_SH 6'h35
`define BILR_OP_SW 6'h36
`define BILR_OP_LOAD_BYTE_UNSIGNED_IMM 6'h38
`define BILR_OP_LOAD_HALF_UNSIGNED_IMM 6'h39
`define BILR_OP_LWI 6'h3A
`define BILR_OP_SBI 6'h3C
`define BILR_OP_SHI 6'h3D
`define BILR_OP_SWI 6'h3E
`define BILR_EXCL_BIT 10
`define BILR_BRU_DELAY 4
`define BILR_BRU_ABS 3
`define BILR_BRU_LINK 2
`define BILR_BRK_CODE 5'h0C
`define BILR_BRC_DELAY 4
`define BILR_CC_EQ 4'h0
`define BILR_CC_NE 4'h1
`define BILR_CC_LT 4'h2
`define BILR_CC_LE 4'h3
`define BILR_CC_GT 4'h4
`define BILR_CC_GE 4'h5
`endif

// [hdl/bilr_pkg.sv]
// Types for the immediate branch, load/store and reservation unit
package bilr_pkg;
	typedef enum logic [1:0] {
		BILR_IDLE = 2'b00,
		BILR_WAIT = 2'b01
	} bilr_state_t;
	typedef struct packed {
		logic [5:0] opcode;
		logic [4:0] rd;
		logic [4:0] ra;
		logic [15:0] low;
	} bilr_instr_t;
	typedef struct packed {
		logic req;
		logic we;
		logic [3:0] be;
		logic [31:0] addr;
		logic [31:0] wdata;
	} bilr_mem_req_t;
	typedef struct packed {
		logic taken;
		logic delayed;
		logic link;
		logic brk;
		logic [31:0] target;
	} bilr_branch_t;
endpackage : bilr_pkg

// [hdl/bilr_lane.sv]
// Byte lane steering for stores and zero-filled extraction for loads
`timescale 1ns/1ns
module bilr_lane
	import bilr_pkg::*;
(
	input wire logic [1:0] size_i,
	input wire logic [1:0] addr_i,
	input wire logic [31:0] src_i,
	input wire logic [31:0] rdata_i,
	output logic [3:0] be_o,
	output logic [31:0] wdata_o,
	output logic [31:0] load_o
);
	// Big-endian lanes: byte 0 sits in bits 31:24
	wire [7:0] rd_byte = rdata_i[8'(31 - 8 * addr_i) -: 8];
	wire [15:0] rd_half = addr_i[1] ? rdata_i[15:0] : rdata_i[31:16];
	assign be_o = (size_i == 2'h0) ? (4'h8 >> addr_i) :
		(size_i == 2'h1) ? (addr_i[1] ? 4'h3 : 4'hC) : 4'hF; // RULE4
	assign wdata_o = (size_i == 2'h0) ? {4{src_i[7:0]}} :
		(size_i == 2'h1) ? {2{src_i[15:0]}} : src_i; // RULE4
	assign load_o = (size_i == 2'h0) ? {24'h000000, rd_byte} :
		(size_i == 2'h1) ? {16'h0000, rd_half} : rdata_i; // RULE4
endmodule : bilr_lane

// [hdl/bilr_unit.sv]
// Immediate branch, load/store and reservation execute unit
`timescale 1ns/1ns
`include "bilr_defines.svh"
module bilr_unit
	import bilr_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic issue_i,
	input wire bilr_instr_t instr_i,
	input wire logic [31:0] pc_i,
	input wire logic [31:0] ra_val_i,
	input wire logic [31:0] rb_val_i,
	input wire logic [31:0] rd_val_i,
	input wire logic flush_event_i,
	input wire logic mem_ack_i,
	input wire logic [31:0] mem_rdata_i,
	output bilr_mem_req_t mem_o,
	output bilr_branch_t branch_o,
	output logic wb_valid_o,
	output logic [4:0] wb_addr_o,
	output logic [31:0] wb_data_o,
	output logic carry_we_o,
	output logic carry_status_bit_o,
	output logic busy_o,
	output logic reserved_o,
	output logic unaligned_exc_o
);
	// ==========================================================
	// Decode
	wire [5:0] op = instr_i.opcode;
	wire [31:0] simm = {{16{instr_i.low[15]}}, instr_i.low};
	wire is_bru = issue_i && op == `BILR_OP_BRU;
	wire is_brc = issue_i && op == `BILR_OP_BRC;
	wire reg_form = !op[3];
	wire is_load = issue_i && op[5:4] == 2'h3 && !op[2] && op[1:0] != 2'h3;
	wire is_store = issue_i && op[5:4] == 2'h3 && op[2] && op[1:0] != 2'h3;
	wire [1:0] size = op[1:0];
	wire excl = reg_form && size == 2'h2 && instr_i.low[`BILR_EXCL_BIT];
	wire [31:0] ea = ra_val_i + (reg_form ? rb_val_i : simm); // RULE4
	// Exclusive forms force word alignment, never trap
	wire [31:0] ea_eff = excl ? {ea[31:2], 2'h0} : ea; // RULE9 RULE10
	wire misalign = !excl && ((size == 2'h2 && ea[1:0] != 2'h0) ||
		(size == 2'h1 && ea[0])); // RULE10
	// ==========================================================
	// Branch resolution
	wire [3:0] cc = instr_i.rd[3:0];
	wire a_zero = ra_val_i == 32'h00000000;
	wire a_neg = ra_val_i[31];
	wire cond_ok = (cc == `BILR_CC_EQ) ? a_zero :
		(cc == `BILR_CC_NE) ? !a_zero :
		(cc == `BILR_CC_LT) ? a_neg :
		(cc == `BILR_CC_LE) ? (a_neg || a_zero) :
		(cc == `BILR_CC_GT) ? !(a_neg || a_zero) :
		(cc == `BILR_CC_GE) ? !a_neg : 1'b0; // RULE1
	wire bru_abs = instr_i.ra[`BILR_BRU_ABS];
	wire bru_brk = instr_i.ra == `BILR_BRK_CODE;
	wire [31:0] rel_tgt = pc_i + simm; // RULE1
	bilr_branch_t br_next;
	assign br_next.taken = is_bru || (is_brc && cond_ok && !instr_i.rd[3]);
	assign br_next.delayed = is_bru ? instr_i.ra[`BILR_BRU_DELAY]
		: instr_i.rd[`BILR_BRC_DELAY]; // RULE2
	assign br_next.link = is_bru && instr_i.ra[`BILR_BRU_LINK]; // RULE3
	assign br_next.brk = is_bru && bru_brk; // RULE3
	assign br_next.target = (is_bru && (bru_abs || bru_brk)) ? simm : rel_tgt; // RULE3
	// ==========================================================
	// Lane steering
	logic [3:0] be;
	logic [31:0] wdata;
	logic [31:0] load_val;
	logic [1:0] size_reg;
	logic [1:0] lane_reg;
	// Store data held from issue: register ports are valid only then
	logic [31:0] src_reg;
	bilr_lane u_lane (
		.size_i(size_reg),
		.addr_i(lane_reg),
		.src_i(src_reg),
		.rdata_i(mem_rdata_i),
		.be_o(be),
		.wdata_o(wdata),
		.load_o(load_val)
	);
	// ==========================================================
	// Reservation and access sequencing
	bilr_state_t state_reg;
	bilr_state_t state_next;
	logic rsv_reg;
	logic load_reg;
	logic [4:0] dst_reg;
	wire idle = state_reg == BILR_IDLE;
	wire waiting = state_reg == BILR_WAIT;
	wire done = waiting && mem_ack_i;
	// Only the flag is kept: no address compare is made
	wire start = (is_load || is_store) && idle && !misalign;
	wire swx = is_store && excl && idle; // RULE6
	wire swx_fail = swx && !rsv_reg; // RULE8
	wire go = start && !swx_fail; // RULE7 RULE11
	wire lwx = is_load && excl && start; // RULE5 RULE12
	wire refuse = (is_load || is_store) && idle && misalign; // RULE10
	wire rsv_next = (flush_event_i || br_next.brk || swx) ? 1'b0 // RULE13 RULE16
		: lwx ? 1'b1 : rsv_reg; // RULE12
	wire carry_next = swx ? swx_fail : carry_status_bit_o; // RULE7 RULE8
	// Limitation: a link issued as any load or store completes loses its write-back
	wire wb_valid_next = done ? load_reg : br_next.link; // RULE3
	wire [4:0] wb_addr_next = done ? dst_reg : instr_i.rd;
	wire [31:0] wb_data_next = done ? load_val : pc_i; // RULE4 RULE5
	bilr_mem_req_t mem_next;
	assign mem_next.req = go || (mem_o.req && !done);
	assign mem_next.we = go ? is_store : mem_o.we;
	assign mem_next.addr = go ? ea_eff : mem_o.addr; // RULE9
	// Reads by other masters are never held off here
	assign mem_next.be = waiting ? be : mem_o.be; // RULE15
	assign mem_next.wdata = waiting ? wdata : mem_o.wdata; // RULE4
	// ==========================================================
	// Sequencer next state
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			BILR_IDLE:
				if (go)
					state_next = BILR_WAIT;
			BILR_WAIT:
				if (mem_ack_i)
					state_next = BILR_IDLE;
			default:
				state_next = BILR_IDLE;
		endcase
	end
	// ==========================================================
	// Sequencer state
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg <= BILR_IDLE;
			busy_o <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			busy_o <= state_next == BILR_WAIT;
		end
	end
	// ==========================================================
	// Reservation flag
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rsv_reg <= 1'b0; // RULE16
			reserved_o <= 1'b0;
		end
		else
		begin
			rsv_reg <= rsv_next;
			reserved_o <= rsv_next;
		end
	end
	// ==========================================================
	// Access capture
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			load_reg <= 1'b0;
			dst_reg <= 5'h00;
			size_reg <= 2'h0;
			lane_reg <= 2'h0;
			src_reg <= 32'h00000000;
		end
		else if (go)
		begin
			load_reg <= is_load;
			dst_reg <= instr_i.rd;
			size_reg <= size;
			lane_reg <= ea_eff[1:0];
			src_reg <= rd_val_i; // RULE4
		end
	end
	// ==========================================================
	// Memory request
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			mem_o <= '0;
		else
			mem_o <= mem_next;
	end
	// ==========================================================
	// Branch and status pulses; the carry status bit holds until the next conditional store
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			branch_o <= '0;
			unaligned_exc_o <= 1'b0;
			carry_we_o <= 1'b0;
			carry_status_bit_o <= 1'b0;
		end
		else
		begin
			branch_o <= br_next; // RULE1 RULE2 RULE3
			unaligned_exc_o <= refuse; // RULE10
			carry_we_o <= swx; // RULE6
			carry_status_bit_o <= carry_next; // RULE7 RULE8
		end
	end
	// ==========================================================
	// Write-back
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wb_valid_o <= 1'b0;
			wb_addr_o <= 5'h00;
			wb_data_o <= 32'h00000000;
		end
		else
		begin
			wb_valid_o <= wb_valid_next;
			wb_addr_o <= wb_addr_next;
			wb_data_o <= wb_data_next;
		end
	end
endmodule : bilr_unit

// [tb/bilr_mem_model.sv]
// Data memory responder with adjustable latency
`timescale 1ns/1ns
module bilr_mem_model
	import bilr_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [3:0] lat_i,
	input wire bilr_mem_req_t mem_i,
	output logic ack_o,
	output logic [31:0] rdata_o
);
	// ========================================
	// Storage and response
	logic [31:0] ram [0:15];
	logic [3:0] wait_reg;
	wire logic hit = mem_i.req && !ack_o && wait_reg >= lat_i;
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wait_reg <= 4'h0;
			ack_o <= 1'b0;
			rdata_o <= 32'h0;
		end
		else
		begin
			ack_o <= hit;
			// Stale data is scrambled so nothing latches it by luck
			rdata_o <= hit ? ram[mem_i.addr[5:2]] : ~rdata_o;
			wait_reg <= (mem_i.req && !hit) ? wait_reg + 4'h1 : 4'h0;
			for (int i = 0; i < 4; i++)
				if (hit && mem_i.we && mem_i.be[i])
					ram[mem_i.addr[5:2]][i*8 +: 8] <= mem_i.wdata[i*8 +: 8];
		end
	end
endmodule : bilr_mem_model

// [tb/bilr_unit_sva.sv]
// Concurrent checks for the execute unit
`timescale 1ns/1ns
module bilr_unit_sva
	import bilr_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic issue_i,
	input wire bilr_instr_t instr_i,
	input wire logic flush_event_i,
	input wire bilr_mem_req_t mem_o,
	input wire bilr_branch_t branch_o,
	input wire logic carry_we_o,
	input wire logic carry_status_bit_o,
	input wire logic busy_o,
	input wire logic reserved_o,
	input wire logic unaligned_exc_o
);
	// ========================================
	// Reservation and branch checks
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	wire logic go = issue_i && !busy_o && !flush_event_i && instr_i.low[10];
	sequence s_lwx; go && instr_i.opcode == 6'h32; endsequence
	sequence s_swx; go && instr_i.opcode == 6'h36; endsequence
	chk_brc_delay: assert property (issue_i && instr_i.opcode == 6'h2F
		|=> !branch_o.taken || branch_o.delayed == $past(instr_i.rd[4])) else $error("delay");
	chk_lwx_set: assert property (s_lwx
		|=> reserved_o && mem_o.req ##1 mem_o.addr[1:0] == 2'h0) else $error("lwx");
	chk_swx_clear: assert property (s_swx
		|=> !reserved_o && carry_we_o) else $error("swx clear");
	chk_swx_pass: assert property (s_swx ##0 reserved_o
		|=> mem_o.req && mem_o.we && !carry_status_bit_o) else $error("swx pass");
	chk_swx_fail: assert property (s_swx ##0 !reserved_o
		|=> !mem_o.req && carry_status_bit_o) else $error("swx fail");
	chk_no_unalign: assert property (s_lwx or s_swx
		|=> !unaligned_exc_o) else $error("unaligned");
	chk_flush_clr: assert property (flush_event_i && !issue_i
		|=> !reserved_o) else $error("flush");
	chk_brk_clr: assert property (issue_i && instr_i.opcode == 6'h2E && instr_i.ra == 5'h0C
		|=> !reserved_o) else $error("break");
endmodule : bilr_unit_sva

// [tb/bilr_unit_tb_top.sv]
// Self-checking bench for the execute unit
`timescale 1ns/1ns
module bilr_unit_tb_top;
	import bilr_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic issue_i = 1'b0;
	logic flush_event_i = 1'b0;
	bilr_instr_t instr_i = 32'h0;
	logic [31:0] pc_i = 32'h1000, ra_val_i = 32'h0, rb_val_i = 32'h0, rd_val_i = 32'h0;
	logic [3:0] lat = 4'h1;
	logic mem_ack_i, wb_valid_o, carry_status_bit_o, busy_o, reserved_o, cy;
	logic unaligned_exc_o, ux;
	logic [4:0] wb_addr_o, wba;
	logic [31:0] mem_rdata_i, wb_data_o, wbd;
	bilr_mem_req_t mem_o;
	bilr_branch_t branch_o, br;
	int err_total = 0, checked = 0, cyc = 0;
	always #10 mclk_i = ~mclk_i;
	bilr_unit u_dut (.mclk_i, .rst_i, .issue_i, .instr_i, .pc_i, .ra_val_i, .rb_val_i, .rd_val_i,
		.flush_event_i, .mem_ack_i, .mem_rdata_i, .mem_o, .branch_o, .wb_valid_o, .wb_addr_o,
		.wb_data_o, .carry_we_o(), .carry_status_bit_o, .busy_o, .reserved_o, .unaligned_exc_o);
	bilr_mem_model u_mem (.mclk_i, .rst_i, .lat_i(lat), .mem_i(mem_o), .ack_o(mem_ack_i),
		.rdata_o(mem_rdata_i));
	// ========================================
	// Shared tasks
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic op(input logic [5:0] o, input logic [4:0] rd, input logic [4:0] ra,
		input logic [15:0] low, input logic [31:0] a, input logic [31:0] b, input logic [31:0] d);
		@(negedge mclk_i);
		instr_i = {o, rd, ra, low};
		ra_val_i = a;
		rb_val_i = b;
		rd_val_i = d;
		issue_i = 1'b1;
		@(negedge mclk_i);
		issue_i = 1'b0;
		br = branch_o;
		cy = carry_status_bit_o;
		ux = unaligned_exc_o;
		for (int i = 0; i < 30 && (busy_o || mem_o.req || wb_valid_o); i++)
		begin
			if (wb_valid_o)
			begin
				wbd = wb_data_o;
				wba = wb_addr_o;
			end
			@(negedge mclk_i);
		end
	endtask : op
	// ========================================
	// Scenarios
	task automatic t_branch();
		logic [5:0] m;
		for (int n = 0; n < 2; n++)
			for (int c = 0; c < 22; c++)
				if (c < 6 || c > 15)
				begin
					m = n ? 6'h0E : 6'h29;
					op(6'h2F, 5'(c), 5'h0, 16'hFFF8, n ? 32'hFFFFFFFF : 32'h0,
						32'h0, 32'h0);
					chk(br.taken, m[c[2:0]]);
					if (m[c[2:0]])
						chk({br.delayed, br.target}, {c[4], pc_i - 32'h8});
				end
		op(6'h2E, 5'h0F, 5'h14, 16'h0040, 32'h0, 32'h0, 32'h0);
		chk({br.taken, br.delayed, br.link, br.target}, {3'h7, pc_i + 32'h40});
		chk({wba, wbd}, {5'h0F, pc_i});
		op(6'h2E, 5'h00, 5'h08, 16'hFF00, 32'h0, 32'h0, 32'h0);
		chk({br.taken, br.delayed, br.target}, {2'h2, 32'hFFFFFF00});
		$display("branch tests done");
	endtask : t_branch
	task automatic t_mem();
		op(6'h36, 5'h1, 5'h2, 16'h0, 32'h8, 32'h8, 32'h11223344);
		op(6'h3C, 5'h1, 5'h2, 16'hFFFD, 32'h14, 32'h0, 32'h556677AB);
		op(6'h30, 5'h1, 5'h2, 16'h0, 32'h10, 32'h1, 32'h0);
		chk(wbd, 32'h000000AB);
		lat = 4'h4;
		op(6'h35, 5'h1, 5'h2, 16'h0, 32'h10, 32'h2, 32'h9999CDEF);
		op(6'h39, 5'h1, 5'h2, 16'h0012, 32'h0, 32'h0, 32'h0);
		chk(wbd, 32'h0000CDEF);
		op(6'h3A, 5'h1, 5'h2, 16'h0010, 32'h0, 32'h0, 32'h0);
		chk({wba, wbd}, {5'h01, 32'h11ABCDEF});
		op(6'h31, 5'h1, 5'h2, 16'h0, 32'h11, 32'h0, 32'h0);
		chk({ux, wbd}, {1'b1, 32'h11ABCDEF});
		$display("load store tests done");
	endtask : t_mem
	task automatic t_resv();
		op(6'h32, 5'h3, 5'h2, 16'h0400, 32'h10, 32'h0, 32'h0);
		chk({reserved_o, wbd}, {1'b1, 32'h11ABCDEF});
		op(6'h36, 5'h3, 5'h2, 16'h0400, 32'h20, 32'h6, 32'hA5A50001);
		chk({cy, reserved_o, ux}, 3'h0);
		op(6'h36, 5'h3, 5'h2, 16'h0400, 32'h24, 32'h0, 32'hDEADBEEF);
		chk({cy, reserved_o}, 2'h2);
		op(6'h32, 5'h3, 5'h2, 16'h0, 32'h24, 32'h0, 32'h0);
		chk(wbd, 32'hA5A50001);
		op(6'h32, 5'h3, 5'h2, 16'h0400, 32'h10, 32'h0, 32'h0);
		op(6'h2E, 5'h10, 5'h0C, 16'h0, 32'h0, 32'h0, 32'h0);
		chk(reserved_o, 1'b0);
		chk({br.taken, br.brk, br.target}, {2'h3, 32'h0});
		op(6'h32, 5'h3, 5'h2, 16'h0400, 32'h10, 32'h0, 32'h0);
		flush_event_i = 1'b1;
		@(negedge mclk_i);
		flush_event_i = 1'b0;
		chk(reserved_o, 1'b0);
		op(6'h32, 5'h3, 5'h2, 16'h0400, 32'h24, 32'h0, 32'h0);
		op(6'h32, 5'h3, 5'h2, 16'h0400, 32'h10, 32'h0, 32'h0);
		op(6'h32, 5'h3, 5'h2, 16'h0, 32'h10, 32'h0, 32'h0);
		chk({reserved_o, wbd}, {1'b1, 32'h11ABCDEF});
		op(6'h36, 5'h3, 5'h2, 16'h0400, 32'h10, 32'h0, 32'h77);
		chk({cy, reserved_o}, 2'h0);
		op(6'h32, 5'h3, 5'h2, 16'h0400, 32'h10, 32'h0, 32'h0);
		rst_i = 1'b1;
		@(negedge mclk_i);
		chk(reserved_o, 1'b0);
		rst_i = 1'b0;
		$display("reservation tests done");
	endtask : t_resv
	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		repeat (20) @(negedge mclk_i);
		rst_i = 1'b0;
		t_branch();
		t_mem();
		t_resv();
		tally_and_finish();
	end
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc > 2000)
		begin
			err_total++;
			tally_and_finish();
		end
	end
endmodule : bilr_unit_tb_top
bind bilr_unit bilr_unit_sva u_sva (.mclk_i, .rst_i, .issue_i, .instr_i, .flush_event_i, .mem_o,
	.branch_o, .carry_we_o, .carry_status_bit_o, .busy_o, .reserved_o, .unaligned_exc_o);
